// ### include/test_io_map.svh
// Offsets, field positions, reset values and timing for the test I/O bank.
// Included by the package users; definitions only.
`ifndef TEST_IO_MAP_SVH
`define TEST_IO_MAP_SVH

`define ADDR_PIN_DRIVER_EN   6'h33
`define ADDR_PIN_IO_VALUE    6'h34
`define ADDR_PROBE_BUS_VIEW  6'h35
`define ADDR_SELF_CHECK      6'h36
`define ADDR_SILICON_REV     6'h37
`define ADDR_TEST_SELECT     6'h31
`define ADDR_COMMAND         6'h01

`define BIT_PIN_IO_ENABLE    7
`define BIT_SECURE_CLK_PIN1  3
`define BIT_RX_NONLINEAR     6
`define BIT_DELIM_ADJUST     5
`define BIT_PRODUCTION       7
`define BIT_RESERVED4        4

`define RESET_PIN_IO_VALUE   8'h00
`define RESET_PIN_DRIVER_EN  8'h80
`define RESET_SELF_CHECK     8'h40
`define RESET_TEST_SELECT    8'h00
`define SELF_TEST_ON         4'h9
`define SELF_TEST_OFF        4'h0
`define CMD_SELF_TEST        4'h3

`define DELIM_MAX_LOW_ETU    11
`define DELIM_MAX_HIGH_ETU   3
`define DELIM_MIN_LOW_ETU    10
`define DELIM_MIN_HIGH_ETU   2
`define DELIM_ADJ_LOW_ETU    11
`define DELIM_ADJ_HIGH_ETU   2
`define DELIM_ADJ_CYCLES     8
`define ETU_CARRIER_CYCLES   128

`endif

// ### include/test_io_pkg.sv
// Types shared by the test I/O bank and its users.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package test_io_pkg;

  typedef enum logic [1:0] {
    HOST_PARALLEL = 2'b00,
    HOST_SPI      = 2'b01,
    HOST_UART     = 2'b10,
    HOST_I2C      = 2'b11
  } host_if_t;

  // Delimiter lengths in carrier cycles
  typedef struct packed {
    logic [11:0] sof_low;
    logic [11:0] sof_high;
    logic [11:0] eof_low;
  } delim_len_t;

  typedef struct packed {
    logic       rx_nonlinear;
    logic       self_test_armed;
    logic [3:0] self_test_code;
  } rx_ctrl_t;

endpackage

`default_nettype wire

// ### rtl/test_io_regs.sv
// Test register bank: pin I/O, probe bus view, self-check control, revision.
// Assumes a single-cycle strobe register port and synchronous pin inputs.
//
// What this block does
// - Serial host plus enable makes pins I/O
// - Driver enable sets direction, value drives
// - Value bits 6..0 map one per pin
// - Secure clock on pin one blocks I/O on pin one only
// - Enabled read returns live pin levels
// - Disabled read returns stored value
// - Read-only view of probe bus
// - Self-check register resets to 40h
// - Bit 6 makes receiver non-linear
// - Adjust clear: width picks max/min delimiters
// - Adjust and width give trimmed lengths
// - Self-test starts only on command
// - Read-only revision, writes ignored
// - Bits 7 and 4 have no function
// - Driver enable bits 6..0 per pin
// - SPI host limits I/O to pins 0..4
// - Secure clock on pin one unless parallel
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "test_io_map.svh"
`default_nettype none

module test_io_regs #(
  parameter int         PINS     = 7,
  parameter logic [7:0] REVISION = 8'hA5  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_reset,
  // Register port
  input  wire logic [5:0]                  i_addr,
  input  wire logic [7:0]                  i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [7:0]                  o_rdata,
  // Surroundings
  input  wire test_io_pkg::host_if_t       i_host_if,
  input  wire logic [7:0]                  i_probe_bus,
  input  wire logic                        i_delim_width,
  input  wire logic                        i_secure_clock,
  // Data pins
  input  wire logic [PINS-1:0]             i_pin,
  output logic      [PINS-1:0]             o_pin,
  output logic      [PINS-1:0]             o_pin_oe,
  // Receiver and framing controls
  output test_io_pkg::rx_ctrl_t            o_rx_ctrl,
  output test_io_pkg::delim_len_t          o_delim_len,
  output logic                             o_self_test_start
);

  logic [7:0]      pin_io_value;
  logic [7:0]      pin_driver_enable_reg;
  logic [7:0]      self_check_control;
  logic [7:0]      test_select;
  logic [PINS-1:0] next_oe;
  logic [PINS-1:0] next_out;
  logic [PINS-1:0] io_allowed;
  logic            pin_io_active;
  logic            secure_clk_routed;
  logic [7:0]      next_rdata;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
    return a == r;
  endfunction

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      self_check_control <= `RESET_SELF_CHECK;
    end else if (i_wr && hit(i_addr, `ADDR_SELF_CHECK)) begin
      self_check_control <= {1'b0, i_wdata[6:5], 1'b0, i_wdata[3:0]};
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_io_value <= `RESET_PIN_IO_VALUE;
    end else if (i_wr && hit(i_addr, `ADDR_PIN_IO_VALUE)) begin
      pin_io_value <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_driver_enable_reg <= `RESET_PIN_DRIVER_EN;
    end else if (i_wr && hit(i_addr, `ADDR_PIN_DRIVER_EN)) begin
      pin_driver_enable_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      test_select <= `RESET_TEST_SELECT;
    end else if (i_wr && hit(i_addr, `ADDR_TEST_SELECT)) begin
      test_select <= i_wdata;
    end
  end

  assign pin_io_active = pin_io_value[`BIT_PIN_IO_ENABLE]
                         && (i_host_if != test_io_pkg::HOST_PARALLEL);
  assign secure_clk_routed = test_select[`BIT_SECURE_CLK_PIN1]
                             && (i_host_if != test_io_pkg::HOST_PARALLEL);

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_allow
      assign io_allowed[g] = !((i_host_if == test_io_pkg::HOST_SPI) && (g > 4));
    end
  endgenerate

  always_comb begin
    next_oe  = '0;
    next_out = '0;
    if (pin_io_active) begin
      next_oe  = pin_driver_enable_reg[PINS-1:0] & io_allowed;
      next_out = pin_io_value[PINS-1:0];
    end
    if (secure_clk_routed) begin
      next_oe[1]  = 1'b1;
      next_out[1] = i_secure_clock;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pin    <= '0;
      o_pin_oe <= '0;
    end else begin
      o_pin    <= next_out;
      o_pin_oe <= next_oe;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    case (i_addr)
      `ADDR_PIN_IO_VALUE: begin
        if (pin_io_value[`BIT_PIN_IO_ENABLE]) begin
          next_rdata = {pin_io_value[7], i_pin};
        end else begin
          next_rdata = pin_io_value;
        end
      end
      `ADDR_PIN_DRIVER_EN:  next_rdata = pin_driver_enable_reg;
      `ADDR_TEST_SELECT:    next_rdata = test_select;
      `ADDR_PROBE_BUS_VIEW: next_rdata = i_probe_bus;
      `ADDR_SELF_CHECK:     next_rdata = self_check_control;
      `ADDR_SILICON_REV:    next_rdata = REVISION;
      default:              next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rx_ctrl <= '0;
    end else begin
      o_rx_ctrl.rx_nonlinear    <= self_check_control[`BIT_RX_NONLINEAR];
      o_rx_ctrl.self_test_armed <= self_check_control[3:0] == `SELF_TEST_ON;
      o_rx_ctrl.self_test_code  <= self_check_control[3:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_self_test_start <= 1'b0;
    end else begin
      o_self_test_start <= i_wr && hit(i_addr, `ADDR_COMMAND)
                           && (i_wdata[3:0] == `CMD_SELF_TEST)
                           && (self_check_control[3:0] == `SELF_TEST_ON);
    end
  end

  localparam logic [11:0] ETU = 12'(`ETU_CARRIER_CYCLES);
  localparam logic [11:0] ADJ = 12'(`DELIM_ADJ_CYCLES);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_delim_len <= '0;
    end else if (self_check_control[`BIT_DELIM_ADJUST] && i_delim_width) begin
      o_delim_len.sof_low  <= 12'(`DELIM_ADJ_LOW_ETU) * ETU - ADJ;
      o_delim_len.sof_high <= 12'(`DELIM_ADJ_HIGH_ETU) * ETU + ADJ;
      o_delim_len.eof_low  <= 12'(`DELIM_ADJ_LOW_ETU) * ETU - ADJ;
    end else if (i_delim_width) begin
      o_delim_len.sof_low  <= 12'(`DELIM_MAX_LOW_ETU) * ETU;
      o_delim_len.sof_high <= 12'(`DELIM_MAX_HIGH_ETU) * ETU;
      o_delim_len.eof_low  <= 12'(`DELIM_MAX_LOW_ETU) * ETU;
    end else begin
      o_delim_len.sof_low  <= 12'(`DELIM_MIN_LOW_ETU) * ETU;
      o_delim_len.sof_high <= 12'(`DELIM_MIN_HIGH_ETU) * ETU;
      o_delim_len.eof_low  <= 12'(`DELIM_MIN_LOW_ETU) * ETU;
    end
  end

  // Assertions
  property p_reset_value;
    @(posedge i_clk) $fell(i_reset) |-> self_check_control == 8'h40;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("bad reset");

  // Two cycles of parallel host let the drivers settle off
  sequence s_parallel_two;
    (i_host_if == test_io_pkg::HOST_PARALLEL) ##1 (i_host_if == test_io_pkg::HOST_PARALLEL);
  endsequence

  property p_parallel_idle;
    @(posedge i_clk) disable iff (i_reset)
      s_parallel_two |-> o_pin_oe == '0;
  endproperty
  a_parallel_idle: assert property (p_parallel_idle) else $error("pins driven");

  property p_spi_limit;
    @(posedge i_clk) disable iff (i_reset)
      $past(i_host_if) == test_io_pkg::HOST_SPI |-> o_pin_oe[PINS-1:5] == '0;
  endproperty
  a_spi_limit: assert property (p_spi_limit) else $error("spi pin driven");

  property p_live_read;
    @(posedge i_clk) disable iff (i_reset)
      i_rd && hit(i_addr, `ADDR_PIN_IO_VALUE) && pin_io_value[7]
      |=> o_rdata[6:0] == $past(i_pin);
  endproperty
  a_live_read: assert property (p_live_read) else $error("live read");

  property p_stored_read;
    @(posedge i_clk) disable iff (i_reset)
      i_rd && hit(i_addr, `ADDR_PIN_IO_VALUE) && !pin_io_value[7]
      |=> o_rdata == $past(pin_io_value);
  endproperty
  a_stored_read: assert property (p_stored_read) else $error("stored read");

  property p_rev_read;
    @(posedge i_clk) disable iff (i_reset)
      i_rd && hit(i_addr, `ADDR_SILICON_REV) |=> o_rdata == REVISION;
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("revision read");

  property p_start_gated;
    @(posedge i_clk) disable iff (i_reset)
      o_self_test_start |-> $past(self_check_control[3:0]) == 4'h9;
  endproperty
  a_start_gated: assert property (p_start_gated) else $error("start");

  property p_nonlinear;
    @(posedge i_clk) disable iff (i_reset)
      // Flops still sit in reset on the releasing edge
      !i_reset |=> o_rx_ctrl.rx_nonlinear == $past(self_check_control[`BIT_RX_NONLINEAR]);
  endproperty
  a_nonlinear: assert property (p_nonlinear) else $error("nonlinear");

  property p_reserved;
    @(posedge i_clk) disable iff (i_reset)
      self_check_control[7] == 1'b0 && self_check_control[4] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved set");

  // Pin I/O owns the pins and the secure clock is off
  sequence s_io_drive;
    pin_io_active && !secure_clk_routed;
  endsequence

  // Armed code plus self-test command in one write
  sequence s_armed_cmd;
    i_wr && hit(i_addr, `ADDR_COMMAND) && (i_wdata[3:0] == `CMD_SELF_TEST)
      && (self_check_control[3:0] == `SELF_TEST_ON);
  endsequence

  property p_pin_value;
    @(posedge i_clk) disable iff (i_reset)
      s_io_drive |=> o_pin == $past(pin_io_value[PINS-1:0]);
  endproperty
  a_pin_value: assert property (p_pin_value) else $error("pin value");

  property p_oe_enabled;
    @(posedge i_clk) disable iff (i_reset)
      s_io_drive |=> (o_pin_oe & ~$past(pin_driver_enable_reg[PINS-1:0])) == '0;
  endproperty
  a_oe_enabled: assert property (p_oe_enabled) else $error("pin driven unenabled");

  property p_oe_off;
    @(posedge i_clk) disable iff (i_reset)
      !pin_io_active && !secure_clk_routed |=> o_pin_oe == '0;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pins driven while idle");

  property p_secure_pin1;
    @(posedge i_clk) disable iff (i_reset)
      secure_clk_routed |=> o_pin_oe[1] && (o_pin[1] == $past(i_secure_clock));
  endproperty
  a_secure_pin1: assert property (p_secure_pin1) else $error("secure pin");

  property p_probe_read;
    @(posedge i_clk) disable iff (i_reset)
      !i_reset && i_rd && hit(i_addr, `ADDR_PROBE_BUS_VIEW)
      |=> o_rdata == $past(i_probe_bus);
  endproperty
  a_probe_read: assert property (p_probe_read) else $error("probe read");

  property p_start_on_cmd;
    @(posedge i_clk) disable iff (i_reset)
      !i_reset ##0 s_armed_cmd |=> o_self_test_start;
  endproperty
  a_start_on_cmd: assert property (p_start_on_cmd) else $error("no start");

  property p_start_needs_cmd;
    @(posedge i_clk) disable iff (i_reset)
      o_self_test_start |-> $past(i_wr) && ($past(i_addr) == `ADDR_COMMAND);
  endproperty
  a_start_needs_cmd: assert property (p_start_needs_cmd) else $error("stray start");

  property p_delim_trim;
    @(posedge i_clk) disable iff (i_reset)
      !i_reset && self_check_control[`BIT_DELIM_ADJUST] && i_delim_width
      |=> o_delim_len == {12'h578, 12'h108, 12'h578};
  endproperty
  a_delim_trim: assert property (p_delim_trim) else $error("trimmed lengths");

  property p_delim_pick;
    @(posedge i_clk) disable iff (i_reset)
      !i_reset && !self_check_control[`BIT_DELIM_ADJUST] && i_delim_width
      |=> o_delim_len == {12'h580, 12'h180, 12'h580};
  endproperty
  a_delim_pick: assert property (p_delim_pick) else $error("max lengths");

  property p_delim_short;
    @(posedge i_clk) disable iff (i_reset)
      !i_reset && !self_check_control[`BIT_DELIM_ADJUST] && !i_delim_width
      |=> o_delim_len == {12'h500, 12'h100, 12'h500};
  endproperty
  a_delim_short: assert property (p_delim_short) else $error("min lengths");

endmodule

`default_nettype wire

// ### tb/pin_circuit.sv
// External circuitry on the seven data pins.
// Assumes the device drives a pin only while its enable is high.
`timescale 1ns/1ps
`default_nettype none

module pin_circuit (
  // Device side
  input  wire logic [6:0] i_pin_out,
  input  wire logic [6:0] i_pin_oe,
  // Level pushed on released pins
  input  wire logic [6:0] i_ext,
  // Resolved levels
  output logic      [6:0] o_level
);
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      o_level[i] = i_pin_oe[i] ? i_pin_out[i] : i_ext[i];
    end
  end
endmodule

`default_nettype wire

// ### tb/test_io_regs_tb.sv
// Self-checking bench for the test register bank.
// Assumes read data one cycle after the read strobe.
`timescale 1ns/1ps
`include "test_io_map.svh"
`default_nettype none

`define EXPECT(g, e) check(g, e)

module test_io_regs_tb;
  logic                       i_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0;
  logic [5:0]                 i_addr = 0;
  logic [7:0]                 i_wdata = 0, i_probe_bus = 0;
  logic                       i_delim_width = 0, i_secure_clock = 0;
  test_io_pkg::host_if_t      i_host_if = test_io_pkg::HOST_SPI;
  logic [6:0]                 ext = 0, lvl, o_pin, o_pin_oe;
  logic [7:0]                 o_rdata, exp_q[$];
  test_io_pkg::rx_ctrl_t      o_rx_ctrl;
  test_io_pkg::delim_len_t    o_delim_len;
  logic                       o_self_test_start, rd_pend = 0;
  int                         num_errors = 0, n_checks = 0, pulses = 0, seed = 79914;

  localparam logic [7:0] REV = 8'h5A;  // Arbitrary value

  always #20 i_clk = ~i_clk;

  test_io_regs #(.REVISION(REV)) dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_host_if(i_host_if),
    .i_probe_bus(i_probe_bus), .i_delim_width(i_delim_width),
    .i_secure_clock(i_secure_clock), .i_pin(lvl), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
    .o_rx_ctrl(o_rx_ctrl), .o_delim_len(o_delim_len), .o_self_test_start(o_self_test_start));

  pin_circuit far (.i_pin_out(o_pin), .i_pin_oe(o_pin_oe), .i_ext(ext), .o_level(lvl));

  task automatic check(input logic [11:0] g, input logic [11:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_clk);
    i_rd <= 0;
  endtask

  // Read results are matched against the oldest note
  always @(posedge i_clk) begin
    if (rd_pend) `EXPECT(o_rdata, exp_q.pop_front());
    rd_pend <= i_rd;
    if (o_self_test_start === 1'b1) pulses++;
  end

  initial begin
    #(3000 * 40);
    num_errors++;
    end_of_test();
  end

  int tbl[3][4] = '{'{0, 1, 1408, 384}, '{0, 0, 1280, 256}, '{1, 1, 1400, 264}};

  initial begin
    repeat (20) @(posedge i_clk);
    i_reset <= 0;
    i_probe_bus <= $random(seed);
    ext <= $random(seed);
    rd(`ADDR_PIN_IO_VALUE, 8'h00);
    rd(`ADDR_SELF_CHECK, 8'h40); // reset value
    `EXPECT(o_rx_ctrl.rx_nonlinear, 1'b1); // nonlinear at reset
    rd(`ADDR_PIN_DRIVER_EN, 8'h80);
    wr(`ADDR_SILICON_REV, 8'h3C);
    rd(`ADDR_SILICON_REV, REV); // read-only revision
    wr(`ADDR_PROBE_BUS_VIEW, 8'h00);
    rd(`ADDR_PROBE_BUS_VIEW, i_probe_bus); // probe bus view
    rd(6'h3F, 8'h00);
    wr(`ADDR_SELF_CHECK, 8'hFF);
    rd(`ADDR_SELF_CHECK, 8'h6F); // bits 7 and 4 dead
    wr(`ADDR_SELF_CHECK, 8'h00); // normal code
    wr(`ADDR_COMMAND, 8'h03);
    repeat (3) @(posedge i_clk);
    `EXPECT(pulses, 0); // no start unarmed
    `EXPECT(o_rx_ctrl.rx_nonlinear, 1'b0); // nonlinear off
    `EXPECT(o_rx_ctrl.self_test_armed, 1'b0); // normal code
    wr(`ADDR_SELF_CHECK, 8'h09); // enable code
    repeat (3) @(posedge i_clk);
    `EXPECT(pulses, 0); // armed alone
    `EXPECT(o_rx_ctrl.self_test_armed, 1'b1); // armed
    wr(`ADDR_COMMAND, 8'h03);
    repeat (3) @(posedge i_clk);
    `EXPECT(pulses, 1); // start on command
    `EXPECT(o_rx_ctrl.self_test_code, 4'h9); // enable code
    for (int i = 0; i < 3; i++) begin
      i_delim_width <= tbl[i][1];
      wr(`ADDR_SELF_CHECK, 8'(tbl[i][0] << 5));
      repeat (3) @(posedge i_clk);
      `EXPECT(o_delim_len.sof_low, 12'(tbl[i][2])); // low phase
      `EXPECT(o_delim_len.sof_high, 12'(tbl[i][3])); // high phase
      `EXPECT(o_delim_len.eof_low, 12'(tbl[i][2])); // end delimiter
    end
    `EXPECT(o_delim_len.eof_low, 12'd1400); // end delimiter
    wr(`ADDR_PIN_DRIVER_EN, 8'h03);
    wr(`ADDR_PIN_IO_VALUE, 8'h83);
    repeat (3) @(posedge i_clk);
    `EXPECT(o_pin_oe, 7'h03); // drivers on
    `EXPECT(o_pin & 7'h03, 7'h03); // driven values
    rd(`ADDR_PIN_IO_VALUE, {1'b1, (ext & 7'h7C) | 7'h03}); // live levels
    wr(`ADDR_PIN_DRIVER_EN, 8'h7F);
    repeat (3) @(posedge i_clk);
    `EXPECT(o_pin_oe, 7'h1F); // SPI limits pins
    i_secure_clock <= 1;
    wr(`ADDR_TEST_SELECT, 8'h08);
    wr(`ADDR_PIN_IO_VALUE, 8'h80);
    repeat (3) @(posedge i_clk);
    `EXPECT(o_pin, 7'h02); // clock owns pin one
    i_secure_clock <= 0;
    repeat (3) @(posedge i_clk);
    `EXPECT(o_pin, 7'h00); // pin one follows clock
    `EXPECT(o_pin_oe, 7'h1F); // pin one still driven
    i_host_if <= test_io_pkg::HOST_PARALLEL;
    repeat (3) @(posedge i_clk);
    `EXPECT(o_pin_oe, 7'h00); // parallel host owns pins
    wr(`ADDR_PIN_IO_VALUE, 8'h55);
    rd(`ADDR_PIN_IO_VALUE, 8'h55); // stored value
    repeat (3) @(posedge i_clk);
    i_reset <= 1;
    repeat (2) @(posedge i_clk);
    i_reset <= 0;
    rd(`ADDR_PIN_IO_VALUE, 8'h00); // stored value cleared
    rd(`ADDR_SELF_CHECK, 8'h40); // reset value again
    rd(`ADDR_TEST_SELECT, 8'h00); // routing cleared
    repeat (3) @(posedge i_clk);
    end_of_test();
  end
endmodule

`default_nettype wire
